// ---- gpol_pad_option_latch.sv ----
// Pad option control with retention latch and fixed pin-role limits.
// Contract
// - Pin zero is application input only.
// - Pin five is only a LED driver and, in debug, the debug wire clock input.
// - Clock output enabled separately on pins four, six.
// - Debug session disables LED drive on pin five.
// - Pull-up disable removes pull-ups, persists in shutdown.
// - Grounded button pin wakes device from shutdown.
// - Matrix option grounds pins three to one asleep.
// - Matrix option: no pull-ups, pull-downs on.
// - Options held in two-bit latch in pads.
// - Strobe rise and fall loads current option bits.
// - Reads return latched options, not pending ones.
// - Strobe bit seven; options cleared by mask.
// - Matrix on pins three-one; disable on two-one.
`timescale 1ns/100ps
`include "gpol_consts.svh"
module gpol_pad_option_latch (
   input  wire logic            clk,
   input  wire logic            reset_n,
   input  wire logic            ctrl_wr,
   input  wire logic [7:0]      ctrl_wdata,
   output logic [7:0]           ctrl_rdata,
   input  wire logic            shutdown,
   input  wire logic            debug_active,
   input  wire logic            led_enable,
   input  wire logic [1:0]      clk_out_sel,
   input  wire logic            clk_out_en,
   input  wire logic            aux_clk,
   input  wire gpol_pkg::gpol_pins_t port_zero_output_latch,
   input  wire gpol_pkg::gpol_pins_t port_zero_drive_config,
   input  wire gpol_pkg::gpol_pins_t pin_in,
   output gpol_pkg::gpol_pins_t pin_out,
   output gpol_pkg::gpol_pins_t pin_oe_n,
   output gpol_pkg::gpol_pins_t pullup_en,
   output gpol_pkg::gpol_pins_t pulldown_en,
   output logic                 led_drive,
   output logic                 crystal_osc_input,
   output logic                 debug_wire_clock,
   output logic                 wake
);
   import gpol_pkg::*;

   // =============================================
   // Control register
   logic [7:0]   ctrl_reg;
   logic [7:0]   ctrl_next;
   gpol_strobe_e st_reg;
   gpol_strobe_e st_next;
   gpol_opt_s    held;
   gpol_opt_if   opt ();

   always_comb begin
      ctrl_next = ctrl_reg;
      if (ctrl_wr) begin
         ctrl_next = ctrl_wdata;
      end
   end

   // The latch opens on the strobe's rising edge and shuts on its fall.
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         GPOL_ST_IDLE: begin
            if (ctrl_reg[`GPOL_BIT_STROBE]) begin
               st_next = GPOL_ST_OPEN;
            end
         end
         GPOL_ST_OPEN: begin
            if (!ctrl_reg[`GPOL_BIT_STROBE]) begin
               st_next = GPOL_ST_IDLE;
            end
         end
         default: st_next = GPOL_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg <= `GPOL_CTRL_RESET;
         st_reg   <= GPOL_ST_IDLE;
      end else begin
         ctrl_reg <= ctrl_next;
         st_reg   <= st_next;
      end
   end

   assign opt.pend.matrix = ctrl_reg[`GPOL_BIT_MATRIX];
   assign opt.pend.roff   = ctrl_reg[`GPOL_BIT_ROFF];
   assign opt.open        = (st_next == GPOL_ST_OPEN);
   assign held            = opt.held;

   gpol_retain_latch u_latch (
      .clk     (clk),
      .reset_n (reset_n),
      .opt     (opt)
   );

   // =============================================
   // Pad control
   // Pins three to one carry the matrix drive lines.
   function automatic logic matrix_pin(int i);
      gpol_pins_t m;
      m = `GPOL_MATRIX_MASK;
      return m[i];
   endfunction

   gpol_pins_t out_next;
   gpol_pins_t oe_n_next;
   gpol_pins_t pu_next;
   gpol_pins_t pd_next;
   logic [7:0] rd_next;
   logic       led_next;
   logic       wake_next;
   gpol_pins_t out_reg;
   gpol_pins_t oe_n_reg;
   gpol_pins_t pu_reg;
   gpol_pins_t pd_reg;
   logic [7:0] rd_reg;
   logic       led_reg;
   logic       osc_reg;
   logic       dck_reg;
   logic       wake_reg;

   always_comb begin
      out_next  = port_zero_output_latch;
      oe_n_next = '1;
      pu_next   = '1;
      pd_next   = '0;
      for (int i = 0; i < 8; i++) begin
         if (i != `GPOL_PIN_OSC && i != `GPOL_PIN_LED) begin
            // Open drain drives only low; push-pull drives both levels.
            oe_n_next[i] = !(port_zero_drive_config[i] || !port_zero_output_latch[i]);
         end
      end
      oe_n_next[`GPOL_PIN_OSC] = 1'b1;
      // The LED pin only ever sinks through the current driver, never as a port.
      oe_n_next[`GPOL_PIN_LED] = 1'b1;
      if (clk_out_en && clk_out_sel[0]) begin
         out_next[`GPOL_PIN_CLK_A]  = aux_clk;
         oe_n_next[`GPOL_PIN_CLK_A] = 1'b0;
      end
      if (clk_out_en && clk_out_sel[1]) begin
         out_next[`GPOL_PIN_CLK_B]  = aux_clk;
         oe_n_next[`GPOL_PIN_CLK_B] = 1'b0;
      end
      if (held.roff) begin
         pu_next = pu_next & ~`GPOL_ROFF_MASK;
      end
      if (held.matrix) begin
         pu_next = pu_next & ~`GPOL_MATRIX_MASK;
         pd_next = `GPOL_MATRIX_MASK;
         if (shutdown) begin
            out_next  = out_next & ~`GPOL_MATRIX_MASK;
            oe_n_next = oe_n_next & ~`GPOL_MATRIX_MASK;
         end
      end
      rd_next = ctrl_reg & `GPOL_OPT_CLEAR_MASK;
      rd_next[`GPOL_BIT_MATRIX] = held.matrix;
      rd_next[`GPOL_BIT_ROFF]   = held.roff;
      led_next = led_enable && port_zero_output_latch[`GPOL_PIN_LED] && !debug_active;
      wake_next = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i != `GPOL_PIN_LED && shutdown && !pin_in[i]) begin
            // The pads pull their own matrix drive lines low, which is no press.
            if (!(held.matrix && matrix_pin(i))) begin
               wake_next = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_reg  <= '1;
         oe_n_reg <= '1;
         pu_reg   <= '1;
         pd_reg   <= '0;
         rd_reg   <= '0;
         led_reg  <= 1'b0;
         osc_reg  <= 1'b0;
         dck_reg  <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         out_reg  <= out_next;
         oe_n_reg <= oe_n_next;
         pu_reg   <= pu_next;
         pd_reg   <= pd_next;
         rd_reg   <= rd_next;
         led_reg  <= led_next;
         osc_reg  <= pin_in[`GPOL_PIN_OSC];
         dck_reg  <= debug_active && pin_in[`GPOL_PIN_LED];
         wake_reg <= wake_next;
      end
   end

   assign pin_out           = out_reg;
   assign pin_oe_n          = oe_n_reg;
   assign pullup_en         = pu_reg;
   assign pulldown_en       = pd_reg;
   assign ctrl_rdata        = rd_reg;
   assign led_drive         = led_reg;
   assign crystal_osc_input = osc_reg;
   assign debug_wire_clock  = dck_reg;
   assign wake              = wake_reg;
endmodule

// ---- gpol_consts.svh ----
// Constants for the pad option latch block.
`ifndef GPOL_CONSTS_SVH
`define GPOL_CONSTS_SVH
// =============================================
// Control register fields
`define GPOL_BIT_STROBE      7
`define GPOL_BIT_MATRIX      6
`define GPOL_BIT_ROFF        5
`define GPOL_OPT_CLEAR_MASK  8'h9F
`define GPOL_CTRL_RESET      8'h00
// =============================================
// Pin roles
`define GPOL_PIN_OSC         0
`define GPOL_PIN_LED         5
`define GPOL_PIN_CLK_A       4
`define GPOL_PIN_CLK_B       6
`define GPOL_MATRIX_MASK     8'h0E
`define GPOL_ROFF_MASK       8'h06
`define GPOL_LED_MAX_UA      1000
`endif

// ---- gpol_pkg.sv ----
// Types for the pad option latch block.
package gpol_pkg;
   typedef enum logic [1:0] {GPOL_ST_IDLE, GPOL_ST_OPEN} gpol_strobe_e;
   typedef struct packed {
      logic matrix;
      logic roff;
   } gpol_opt_s;
   typedef logic [7:0] gpol_pins_t;
endpackage

// ---- gpol_opt_if.sv ----
// Interface carrying option values between strobe logic and retention latch.
`timescale 1ns/100ps
interface gpol_opt_if;
   import gpol_pkg::*;
   gpol_opt_s pend;
   logic      open;
   gpol_opt_s held;
   modport ctl (output pend, output open, input held);
   modport lat (input pend, input open, output held);
endinterface

// ---- gpol_retain_latch.sv ----
// Two-bit option retention latch model, clocked for synthesis.
`timescale 1ns/100ps
`include "gpol_consts.svh"
module gpol_retain_latch (
   input  wire logic clk,
   input  wire logic reset_n,
   gpol_opt_if.lat   opt
);
   import gpol_pkg::*;
   gpol_opt_s held_reg;
   gpol_opt_s held_next;
   // =============================================
   // Retention storage
   // The value is held by the pads through shutdown; only power-on clears it.
   always_comb begin
      held_next = held_reg;
      if (opt.open) begin
         held_next = opt.pend;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         held_reg <= '0;
      end else begin
         held_reg <= held_next;
      end
   end
   assign opt.held = held_reg;
endmodule

// ---- gpol_chk.sv ----
// Port checker for the pad option latch.
`timescale 1ns/100ps
module gpol_chk (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   input wire logic [7:0] ctrl_rdata,
   input wire logic       shutdown,
   input wire logic       debug_active,
   input wire logic [7:0] pin_in,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] pullup_en,
   input wire logic [7:0] pulldown_en,
   input wire logic       led_drive,
   input wire logic       wake
);
   // ==========================================
   // Shadow of the strobe bit, rebuilt from writes.
   logic str_reg;
   logic str_next;
   always_comb str_next = ctrl_wr ? ctrl_wdata[7] : str_reg;
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n) str_reg <= 1'b0;
      else str_reg <= str_next;
   // ==========================================
   // Properties.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_osc_in; pin_oe_n[0]; endproperty
   a_osc_in: assert property (p_osc_in) else $error("pin0 driven");
   property p_led; pin_oe_n[5]; endproperty
   a_led: assert property (p_led) else $error("pin5 port driven");
   property p_dbg; debug_active |=> !led_drive; endproperty
   a_dbg: assert property (p_dbg) else $error("led on in debug");
   property p_wake; $past(shutdown) && ($past(pin_in) | 8'h2E) != 8'hFF |-> wake; endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_msl; ctrl_rdata[6] && $past(ctrl_rdata[6]) && $past(shutdown)
      |-> pin_oe_n[3:1] == 3'b000 && pin_out[3:1] == 3'b000; endproperty
   a_msl: assert property (p_msl) else $error("matrix pins not low");
   property p_mpl; ctrl_rdata[6] |-> !pullup_en[3:1] && pulldown_en[3:1] == 3'b111; endproperty
   a_mpl: assert property (p_mpl) else $error("matrix pulls wrong");
   property p_roff; ctrl_rdata[5] |-> pullup_en[2:1] == 2'b00; endproperty
   a_roff: assert property (p_roff) else $error("pullups kept");
   // A change of the held options needs a strobe two or so edges before.
   property p_hold; !$stable(ctrl_rdata[6:5])
      |-> $past(str_reg) || $past(str_reg, 2) || $past(str_reg, 3); endproperty
   a_hold: assert property (p_hold) else $error("options moved");
endmodule
bind gpol_pad_option_latch gpol_chk u_chk (.*);

// ---- gpol_buttons.sv ----
// Push-button model: keys to ground and one matrix key.
`timescale 1ns/100ps
module gpol_buttons (
   input wire logic       clk,
   input wire logic [7:0] press,
   input wire logic       mx_key,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] pullup_en,
   input wire logic [7:0] pulldown_en,
   output logic [7:0]     pin_in
);
   logic [7:0] pad;
   logic [7:0] flt_reg = 8'h00;
   // ==========================================
   // A floating pad toggles so a stale level is never read.
   always @(posedge clk) flt_reg <= ~flt_reg;
   always_comb pad = (~pin_oe_n & pin_out) | (pin_oe_n & (pullup_en | (~pulldown_en & flt_reg)));
   // The matrix key ties pin zero to a low pin one.
   always_comb pin_in = pad & ~press & ~{7'h00, mx_key & ~pad[1]};
endmodule

// ---- gpol_pad_option_latch_test.sv ----
// Self-checking bench for the pad option latch.
`timescale 1ns/100ps
module gpol_pad_option_latch_test;
   import gpol_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, ctrl_wr = 1'b0, shutdown = 1'b0, mx_key = 1'b0;
   logic debug_active = 1'b0, led_enable = 1'b0, clk_out_en = 1'b0, aux_clk = 1'b0;
   logic [1:0] clk_out_sel = 2'b00;
   logic [7:0] ctrl_wdata = 8'h00, press = 8'h00, ctrl_rdata;
   gpol_pins_t port_zero_output_latch = 8'hFF, port_zero_drive_config = 8'h00;
   gpol_pins_t pin_in, pin_out, pin_oe_n, pullup_en, pulldown_en;
   logic led_drive, crystal_osc_input, debug_wire_clock, wake;
   logic [31:0] rs = 32'h0000_0A50;
   logic [11:0] pat = 12'hD5F;
   int n_mismatch = 0, num_checks = 0, mx = 0, ro = 0;
   gpol_pad_option_latch u_dut (.*);
   gpol_buttons u_btn (.*);
   always #50 clk = ~clk;
   // ==========================================
   // Helpers.
   function automatic logic [31:0] xs(logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction
   // Clock pins show the clock when enabled, otherwise their port bit.
   function automatic logic [1:0] pin_exp(int p);
      logic drv;
      drv = port_zero_drive_config[p] | ~port_zero_output_latch[p];
      if (clk_out_en && clk_out_sel[p / 2 - 2]) return {1'b0, aux_clk};
      return {~drv, port_zero_output_latch[p]};
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task automatic w(int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic wr(logic [7:0] v);
      @(posedge clk);
      ctrl_wr <= 1'b1;
      ctrl_wdata <= v;
      @(posedge clk);
      ctrl_wr <= 1'b0;
   endtask
   // Other bits stay put across the strobe pulse, as the latch expects.
   task automatic opt(int m, int r);
      logic [7:0] v;
      logic [7:0] pu;
      rs = xs(rs);
      v = {1'b0, m[0], r[0], rs[4:0]};
      wr(v);
      w(3);
      chk("pending", ctrl_rdata, {1'b0, mx[0], ro[0], rs[4:0]});
      wr(v | 8'h80);
      wr(v);
      mx = m;
      ro = r;
      pu = ~(mx ? 8'h0E : 8'h00) & ~(ro ? 8'h06 : 8'h00);
      w(4);
      chk("rdata", ctrl_rdata, v);
      chk("pullup", pullup_en, pu);
      chk("pulldown", pulldown_en, mx ? 8'h0E : 8'h00);
   endtask
   // ==========================================
   // Sequence.
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      w(1);
      chk("oe_n", pin_oe_n, 8'hFF);
      chk("pullup", pullup_en, 8'hFF);
      for (int k = 0; k < 6; k++) opt(k % 3 == 2, k % 3 == 1);
      for (int k = 0; k < 40; k++) begin
         rs = xs(rs);
         @(posedge clk);
         {debug_active, led_enable, clk_out_sel, clk_out_en, aux_clk} <= rs[5:0];
         port_zero_output_latch <= rs[15:8];
         port_zero_drive_config <= rs[23:16];
         w(1);
         chk("led", led_drive, led_enable&port_zero_output_latch[5]&~debug_active);
         chk("oe05", {pin_oe_n[5], pin_oe_n[0]}, 2'b11);
         chk("ck6", {pin_oe_n[6], pin_out[6]}, pin_exp(6));
         chk("ck4", {pin_oe_n[4], pin_out[4]}, pin_exp(4));
         chk("dck", debug_wire_clock, debug_active);
      end
      @(posedge clk);
      {debug_active, led_enable, clk_out_en} <= 3'b000;
      port_zero_output_latch <= 8'hFF;
      port_zero_drive_config <= 8'h00;
      opt(1, 0);
      @(posedge clk);
      shutdown <= 1'b1;
      w(2);
      chk("sleep_oe", pin_oe_n & 8'h0E, 8'h00);
      chk("sleep_out", pin_out & 8'h0E, 8'h00);
      chk("wake", wake, 1'b0);
      @(posedge clk);
      mx_key <= 1'b1;
      w(2);
      chk("wake", wake, 1'b1);
      @(posedge clk);
      shutdown <= 1'b0;
      opt(0, 0);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         port_zero_output_latch <= {4'hF, pat[9 - 3 * k +: 3], 1'b1};
         w(3);
         chk("scan", crystal_osc_input, pat[9 - 3 * k]);
      end
      @(posedge clk);
      mx_key <= 1'b0;
      press <= 8'h80;
      shutdown <= 1'b1;
      w(2);
      chk("wake", wake, 1'b1);
      summarize();
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      summarize();
   end
endmodule
